// [logic/enc_pkg.sv]
// Constants and types shared by the six-axis encoder counter.
// How it works
// - Six identical counters, each fed by channel A, channel B and index.
// - Step/direction style: count each A rise, direction taken from B.
// - Quadrature style: every lone A or B edge counts, four per line.
// - While the per-counter clear bit is set, count and position read zero.
// - Raw count follows the same edges but ignores clear and index.
// - Count is signed 32-bit; position is count divided by the scale.
// - An armed index edge rounds or zeroes the count, then disarms.
// - Round action snaps to the nearest counts-per-turn multiple; else zero.
// - Index polarity bit picks the falling edge, otherwise the rising one.
// - Velocity comes from timing the gap between successive counts.
// - Velocity reads zero when slower than the configured limit.
// - Counting runs on its own; the host only samples the results.
`default_nettype none
package enc_pkg;
	localparam int NUM_AXES = 6;
	// Per-axis register block, axis n at n * 16.
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CPR = 8'h04;
	localparam logic [7:0] OFS_SCALE = 8'h08;
	localparam logic [7:0] OFS_SLOW = 8'h0c;
	// Snapshot block.
	localparam logic [7:0] OFS_SCOUNT = 8'h60;
	localparam logic [7:0] OFS_SRAW = 8'h64;
	localparam logic [7:0] OFS_SPOS = 8'h68;
	localparam logic [7:0] OFS_SVEL = 8'h6c;
	localparam logic [7:0] OFS_SNAP = 8'h70;
	// Control register fields.
	localparam int CTRL_STEPDIR = 0;
	localparam int CTRL_ROUND = 1;
	localparam int CTRL_FALL = 2;
	localparam int CTRL_CLEAR = 3;
	localparam int CTRL_ARM = 4;
	localparam int SNAP_BUSY = 31;
	// Reset values.
	localparam logic [4:0] CTRL_RST = 5'h00;
	localparam logic [31:0] CPR_RST = 32'h0000_0000;
	localparam logic [31:0] SCALE_RST = 32'h0000_0001;
	// Timing: default slowest measurable period.
	localparam int CLK_PERIOD_NS = 40;
	localparam int SLOW_LIMIT_MS = 100;
	localparam int SLOW_LIMIT_CYC = SLOW_LIMIT_MS * 1000000 / CLK_PERIOD_NS;
	// Position is a signed 16.16 fixed-point quotient.
	localparam int POS_FRAC = 16;
	localparam logic [5:0] DIV_LAST = 6'h2f;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		DIV_IDLE = 2'b01,
		DIV_RUN = 2'b10
	} div_state_t;
endpackage
`default_nettype wire

// [logic/six_axis_encoder_counter.sv]
// Six-axis incremental encoder counter with an AXI4-Lite register slave.
`timescale 1ns/100ps
`default_nettype none
module six_axis_encoder_counter import enc_pkg::*; #(
	parameter logic [31:0] SLOW_LIMIT = 32'(SLOW_LIMIT_CYC)
) (
	// Clock and reset.
	input wire logic i_clock,
	input wire logic i_rst_n,
	// Encoder pins, one bit per axis.
	input wire logic [NUM_AXES-1:0] i_chan_a,
	input wire logic [NUM_AXES-1:0] i_chan_b,
	input wire logic [NUM_AXES-1:0] i_index,
	// AXI4-Lite write address and data.
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [7:0] i_awaddr,
	input wire logic i_wvalid,
	output logic o_wready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	// AXI4-Lite write response.
	output logic o_bvalid,
	input wire logic i_bready,
	output logic [1:0] o_bresp,
	// AXI4-Lite read.
	input wire logic i_arvalid,
	output logic o_arready,
	input wire logic [7:0] i_araddr,
	output logic o_rvalid,
	input wire logic i_rready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp
);
	// Bit 0 is channel A, bit 1 channel B, bit 2 index.
	typedef struct packed {
		logic [2:0] s1;
		logic [2:0] s2;
		logic [2:0] s3;
		logic [2:0] filt;
		logic [4:0] ctrl;
		logic [31:0] cpr;
		logic [31:0] scale;
		logic [31:0] slow;
		logic [31:0] count;
		logic [31:0] raw;
		logic [31:0] elapsed;
		logic [31:0] period;
		logic dir;
	} axis_t;

	typedef struct packed {
		axis_t [NUM_AXES-1:0] ax;
		logic aw_got;
		logic w_got;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		div_state_t dst;
		logic [5:0] dcnt;
		logic [32:0] rem;
		logic [47:0] quo;
		logic [31:0] dvs;
		logic neg;
		logic [2:0] sel;
		logic [31:0] scount;
		logic [31:0] sraw;
		logic [31:0] spos;
		logic [31:0] svel;
	} state_t;

	state_t st;
	state_t next_st;

	// Word-aligned addresses inside the axis and snapshot blocks are mapped.
	function automatic logic mapped(input logic [7:0] a);
		return (a[1:0] == 2'h0) && (a[7:4] < 4'h7 || a == OFS_SNAP);
	endfunction

	// True when the address falls in one of the per-axis blocks.
	function automatic logic in_axis(input logic [7:0] a);
		return a[7:4] < 4'(NUM_AXES);
	endfunction

	// Applies byte enables to an old register value.
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [31:0] mag(input logic [31:0] v);
		return v[31] ? -v : v;
	endfunction

	// Offset of a count above the counts-per-turn grid, in 0 to m-1.
	// A full remainder per axis costs area, but rounding stays right
	// when the grid is programmed after the axis has already moved.
	function automatic logic [31:0] grid_off(input logic [31:0] c,
		input logic [31:0] m);
		logic [31:0] r;
		r = (m == 32'h0000_0000) ? 32'h0000_0000 : mag(c) % m;
		if (c[31] && r != 32'h0000_0000) begin
			r = m - r;
		end
		return r;
	endfunction

	// Next-state logic for counters, bus slave and position divider.
	always_comb begin
		logic [2:0] f;
		logic [2:0] o;
		logic up;
		logic dn;
		logic ev;
		logic bit_q;
		logic [31:0] m;
		logic [31:0] rc;
		logic [31:0] ph;
		logic [32:0] t;
		logic [2:0] wa;
		axis_t a;
		f = 3'h0;
		o = 3'h0;
		up = 1'b0;
		dn = 1'b0;
		ev = 1'b0;
		bit_q = 1'b0;
		m = 32'h0000_0000;
		rc = 32'h0000_0000;
		ph = 32'h0000_0000;
		t = 33'h0_0000_0000;
		wa = 3'h0;
		a = st.ax[0];
		next_st = st;

		// One pass per axis; every counter is the same logic.
		for (int i = 0; i < NUM_AXES; i++) begin
			a = st.ax[i];
			// Three stages; the first feeds only the second.
			next_st.ax[i].s1 = {i_index[i], i_chan_b[i], i_chan_a[i]};
			next_st.ax[i].s2 = a.s1;
			next_st.ax[i].s3 = a.s2;
			// A level is accepted once stages two and three agree.
			f = (a.s2 & a.s3) | (a.filt & (a.s2 ^ a.s3));
			o = a.filt;
			next_st.ax[i].filt = f;
			if (a.ctrl[CTRL_STEPDIR]) begin
				// Only the rising edge of A counts; B high means up.
				up = f[0] & ~o[0] & f[1];
				dn = f[0] & ~o[0] & ~f[1];
			end else begin
				// A lone change of A or B counts; both at once is lost.
				up = ((f[0] ^ o[0]) ^ (f[1] ^ o[1])) & (f[0] ^ o[1]);
				dn = ((f[0] ^ o[0]) ^ (f[1] ^ o[1])) & ~(f[0] ^ o[1]);
			end
			ev = a.ctrl[CTRL_FALL] ? (o[2] & ~f[2]) : (~o[2] & f[2]);
			m = mag(a.cpr);
			rc = a.count;
			// Raw count sees every edge and nothing else.
			if (up) begin
				next_st.ax[i].raw = a.raw + 32'h0000_0001;
			end else if (dn) begin
				next_st.ax[i].raw = a.raw - 32'h0000_0001;
			end
			// Main count follows the same edges as the raw count.
			if (up) begin
				rc = rc + 32'h0000_0001;
			end else if (dn) begin
				rc = rc - 32'h0000_0001;
			end
			// The grid offset comes from the count itself, after this
			// cycle's edge, so an index in the same cycle sees it.
			ph = grid_off(rc, m);
			if (ev && a.ctrl[CTRL_ARM]) begin
				if (a.ctrl[CTRL_ROUND]) begin
					// Snap to the nearest multiple of counts per turn.
					if ({ph, 1'b0} < {1'b0, m}) begin
						rc = rc - ph;
					end else begin
						rc = rc + (m - ph);
					end
				end else begin
					rc = 32'h0000_0000;
				end
				next_st.ax[i].ctrl[CTRL_ARM] = 1'b0;
			end
			if (a.ctrl[CTRL_CLEAR]) begin
				rc = 32'h0000_0000;
			end
			next_st.ax[i].count = rc;
			// The gap timer saturates instead of wrapping to a fast value.
			if (up || dn) begin
				next_st.ax[i].period = a.elapsed;
				next_st.ax[i].elapsed = 32'h0000_0001;
				next_st.ax[i].dir = dn;
			end else if (a.elapsed != 32'hffff_ffff) begin
				next_st.ax[i].elapsed = a.elapsed + 32'h0000_0001;
			end
		end

		// Write address and data are accepted in either order.
		if (i_awvalid && st.awready) begin
			next_st.aw_got = 1'b1;
			next_st.awaddr = i_awaddr;
		end
		if (i_wvalid && st.wready) begin
			next_st.w_got = 1'b1;
			next_st.wdata = i_wdata;
			next_st.wstrb = i_wstrb;
		end
		// A bus write comes after the counters, so arming wins over a
		// hardware disarm in the same cycle.
		if (st.aw_got && st.w_got && !st.bvalid) begin
			wa = st.awaddr[6:4];
			next_st.aw_got = 1'b0;
			next_st.w_got = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = mapped(st.awaddr) ? RESP_OKAY : RESP_SLVERR;
			if (mapped(st.awaddr) && in_axis(st.awaddr)) begin
				a = st.ax[wa];
				unique case ({4'h0, st.awaddr[3:0]})
					OFS_CTRL: next_st.ax[wa].ctrl = 5'(merge({27'h0, a.ctrl},
						st.wdata, st.wstrb));
					OFS_CPR: next_st.ax[wa].cpr = merge(a.cpr, st.wdata,
						st.wstrb);
					OFS_SCALE: next_st.ax[wa].scale = merge(a.scale,
						st.wdata, st.wstrb);
					default: next_st.ax[wa].slow = merge(a.slow, st.wdata,
						st.wstrb);
				endcase
			end else if (st.awaddr == OFS_SNAP && st.dst == DIV_IDLE &&
				st.wstrb[0] && st.wdata[2:0] < 3'(NUM_AXES)) begin
				// Capture one axis in a single cycle for a coherent set.
				wa = st.wdata[2:0];
				a = st.ax[wa];
				next_st.sel = wa;
				next_st.scount = a.count;
				next_st.sraw = a.raw;
				// Slower than the limit, or never moved, reads as zero.
				if (a.period == 32'h0000_0000 || a.period > a.slow ||
					a.elapsed > a.slow) begin
					next_st.svel = 32'h0000_0000;
				end else begin
					next_st.svel = a.dir ? -a.period : a.period;
				end
				// Start the shared serial divide for the position.
				next_st.neg = a.count[31] ^ a.scale[31];
				next_st.quo = {mag(a.count), 16'h0000};
				next_st.dvs = mag(a.scale);
				next_st.rem = 33'h0_0000_0000;
				next_st.dcnt = 6'h00;
				next_st.dst = DIV_RUN;
			end
		end
		if (st.bvalid && i_bready) begin
			next_st.bvalid = 1'b0;
		end
		next_st.awready = !next_st.aw_got && !next_st.bvalid;
		next_st.wready = !next_st.w_got && !next_st.bvalid;

		// Restoring divide, one quotient bit per cycle; sharing one
		// divider trades latency for area across the six axes.
		if (st.dst == DIV_RUN) begin
			t = {st.rem[31:0], st.quo[47]};
			bit_q = t >= {1'b0, st.dvs};
			next_st.rem = bit_q ? t - {1'b0, st.dvs} : t;
			next_st.quo = {st.quo[46:0], bit_q};
			next_st.dcnt = st.dcnt + 6'h01;
			if (st.dcnt == DIV_LAST) begin
				next_st.dst = DIV_IDLE;
				if (st.dvs == 32'h0000_0000) begin
					next_st.spos = 32'h0000_0000;
				end else if (st.neg) begin
					next_st.spos = -{st.quo[30:0], bit_q};
				end else begin
					next_st.spos = {st.quo[30:0], bit_q};
				end
			end
		end

		// Read channel answers one cycle after the address is taken.
		if (i_arvalid && st.arready) begin
			next_st.rvalid = 1'b1;
			next_st.rresp = mapped(i_araddr) ? RESP_OKAY : RESP_SLVERR;
			next_st.rdata = 32'h0000_0000;
			wa = i_araddr[6:4];
			if (mapped(i_araddr) && in_axis(i_araddr)) begin
				a = st.ax[wa];
				unique case ({4'h0, i_araddr[3:0]})
					OFS_CTRL: next_st.rdata = {27'h0, a.ctrl};
					OFS_CPR: next_st.rdata = a.cpr;
					OFS_SCALE: next_st.rdata = a.scale;
					default: next_st.rdata = a.slow;
				endcase
			end else if (mapped(i_araddr)) begin
				case (i_araddr)
					OFS_SCOUNT: next_st.rdata = st.scount;
					OFS_SRAW: next_st.rdata = st.sraw;
					OFS_SPOS: next_st.rdata = st.spos;
					OFS_SVEL: next_st.rdata = st.svel;
					default: begin
						next_st.rdata[SNAP_BUSY] = st.dst == DIV_RUN;
						next_st.rdata[2:0] = st.sel;
					end
				endcase
			end
		end
		if (st.rvalid && i_rready) begin
			next_st.rvalid = 1'b0;
		end
		next_st.arready = !next_st.rvalid;
	end

	// State register; reset loads constants only.
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			st <= '0;
			st.dst <= DIV_IDLE;
			for (int i = 0; i < NUM_AXES; i++) begin
				st.ax[i].ctrl <= CTRL_RST;
				st.ax[i].cpr <= CPR_RST;
				st.ax[i].scale <= SCALE_RST;
				st.ax[i].slow <= SLOW_LIMIT;
			end
		end else begin
			st <= next_st;
		end
	end

	// Every output is a field of the state register.
	assign o_awready = st.awready;
	assign o_wready = st.wready;
	assign o_bvalid = st.bvalid;
	assign o_bresp = st.bresp;
	assign o_arready = st.arready;
	assign o_rvalid = st.rvalid;
	assign o_rdata = st.rdata;
	assign o_rresp = st.rresp;
endmodule
`default_nettype wire

// [bench/enc_asserts.sv]
// Register bus protocol checker for the six-axis encoder counter.
`timescale 1ns/100ps
`default_nettype none
module enc_asserts import enc_pkg::*; (
	// Clock and reset.
	input wire logic i_clock,
	input wire logic i_rst_n,
	// Register bus.
	input wire logic i_awvalid,
	input wire logic o_awready,
	input wire logic i_wvalid,
	input wire logic o_wready,
	input wire logic o_bvalid,
	input wire logic i_bready,
	input wire logic [1:0] o_bresp,
	input wire logic i_arvalid,
	input wire logic o_arready,
	input wire logic [7:0] i_araddr,
	input wire logic o_rvalid,
	input wire logic i_rready,
	input wire logic [31:0] o_rdata,
	input wire logic [1:0] o_rresp
);
	// One clock domain, so one default clock and disable.
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	property p_b_hold;
		o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("bresp dropped");
	// A read data word must not change while the host waits for it.
	property p_r_hold;
		o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("rdata moved");
	property p_ar_busy;
		o_rvalid |-> !o_arready;
	endproperty
	a_ar_busy: assert property (p_ar_busy) else $error("ar open");
	property p_aw_busy;
		o_bvalid |-> !o_awready && !o_wready;
	endproperty
	a_aw_busy: assert property (p_aw_busy) else $error("aw open");
	property p_r_ans;
		i_arvalid && o_arready |=> o_rvalid;
	endproperty
	a_r_ans: assert property (p_r_ans) else $error("no rvalid");
	property p_b_ans;
		i_awvalid && o_awready && i_wvalid && o_wready |=> !o_bvalid ##1 o_bvalid;
	endproperty
	a_b_ans: assert property (p_b_ans) else $error("bvalid late");
	property p_r_done;
		o_rvalid && i_rready |=> !o_rvalid;
	endproperty
	a_r_done: assert property (p_r_done) else $error("rvalid stuck");
	property p_unmap;
		i_arvalid && o_arready && i_araddr > 8'h70 |=> o_rresp == RESP_SLVERR;
	endproperty
	a_unmap: assert property (p_unmap) else $error("no slverr");
endmodule
bind six_axis_encoder_counter enc_asserts i_chk (.i_clock(i_clock),
	.i_rst_n(i_rst_n), .i_awvalid(i_awvalid), .o_awready(o_awready),
	.i_wvalid(i_wvalid), .o_wready(o_wready), .o_bvalid(o_bvalid),
	.i_bready(i_bready), .o_bresp(o_bresp), .i_arvalid(i_arvalid),
	.o_arready(o_arready), .i_araddr(i_araddr), .o_rvalid(o_rvalid),
	.i_rready(i_rready), .o_rdata(o_rdata), .o_rresp(o_rresp));
`default_nettype wire

// [bench/enc_source.sv]
// Encoder and step/direction source driving the six axis pin pairs.
`timescale 1ns/100ps
`default_nettype none
module enc_source (
	// Clock and step command.
	input wire logic i_clock,
	input wire logic i_step,
	input wire logic [2:0] i_axis,
	input wire logic i_dir,
	input wire logic [5:0] i_stepdir,
	// Encoder pins.
	output logic [5:0] o_a,
	output logic [5:0] o_b
);
	logic [1:0] phase [6] = '{default: 2'h0};
	// One step moves one axis a quarter line; pins stand still between steps.
	always @(posedge i_clock) begin
		if (i_step) begin
			phase[i_axis] <= i_dir ? phase[i_axis] + 2'h1 : phase[i_axis] - 2'h1;
		end
	end
	// Gray code with A leading B going up; step mode toggles A.
	always_comb begin
		for (int n = 0; n < 6; n++) begin
			o_a[n] = i_stepdir[n] ? phase[n][0] : phase[n][0] ^ phase[n][1];
			o_b[n] = i_stepdir[n] ? i_dir : phase[n][1];
		end
	end
endmodule
`default_nettype wire

// [bench/six_axis_encoder_counter_test.sv]
// Self-checking bench for the six-axis encoder counter.
`timescale 1ns/100ps
`default_nettype none
module six_axis_encoder_counter_test import enc_pkg::*;;
	logic i_clock = 0;
	logic rst_n = 0;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, rdv;
	logic [1:0] bresp, rresp, resp;
	logic [5:0] chan_a, chan_b, index = 0, mask = 0;
	logic step = 0, dir = 1;
	logic [2:0] axis = 0;
	int failures = 0, cmp_count = 0, cycles = 0;
	always #20 i_clock = ~i_clock;
	// Short velocity limit keeps the slow-motion wait brief.
	six_axis_encoder_counter #(.SLOW_LIMIT(32'h0000_00c8)) i_dut (
		.i_clock(i_clock), .i_rst_n(rst_n), .i_chan_a(chan_a),
		.i_chan_b(chan_b), .i_index(index), .i_awvalid(awvalid),
		.o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wvalid),
		.o_wready(wready), .i_wdata(wdata), .i_wstrb(4'hf),
		.o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
		.i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
		.o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp));
	enc_source i_src (.i_clock(i_clock), .i_step(step), .i_axis(axis),
		.i_dir(dir), .i_stepdir(mask), .o_a(chan_a), .o_b(chan_b));
	task automatic test_done();
		$display("Totals: %0d mismatches in %0d compares", failures, cmp_count);
		if (failures == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// A hang ends the run as a failure.
	always @(posedge i_clock) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			failures++;
			$display("MISMATCH %0t: timeout", $time);
			test_done();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_resp(input logic [1:0] exp);
		cmp_count++;
		if (resp !== exp) begin
			failures++;
			$display("MISMATCH %0t: response %h", $time, resp);
		end
	endtask
	// Address and data are released each at its own ready.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		do begin
			@(posedge i_clock);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
		end while (awvalid && !awready || wvalid && !wready);
		// Ready follows the answer, so the hold checks see a wait.
		do @(posedge i_clock); while (!bvalid);
		bready <= 1;
		@(posedge i_clock);
		bready <= 0;
		resp = bresp;
	endtask
	task automatic rdr(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1;
		do @(posedge i_clock); while (!arready);
		arvalid <= 0;
		do @(posedge i_clock); while (!rvalid);
		rready <= 1;
		@(posedge i_clock);
		rready <= 0;
		rdv = rdata;
		resp = rresp;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		rdr(a);
		chk(rdv, exp);
	endtask
	// Capture one axis and wait until its position is ready.
	task automatic snap(input logic [2:0] ax);
		wr(OFS_SNAP, {29'h0, ax});
		do rdr(OFS_SNAP); while (rdv[SNAP_BUSY] !== 1'b0);
	endtask
	// Steps spaced gap clocks apart, then time for the counts to land.
	task automatic steps(input int n, input logic d, input int gap);
		dir <= d;
		repeat (n) begin
			step <= 1;
			@(posedge i_clock);
			step <= 0;
			repeat (gap - 1) @(posedge i_clock);
		end
		repeat (10) @(posedge i_clock);
	endtask
	task automatic t_reset();
		rdc(8'h20, 32'h0000_0000);
		rdc(8'h24, 32'h0000_0000);
		rdc(8'h28, 32'h0000_0001);
		rdr(8'h80);
		chk_resp(RESP_SLVERR);
		wr(8'h80, 32'h0000_0001);
		chk_resp(RESP_SLVERR);
	endtask
	task automatic t_quad_clear();
		steps(8, 1, 6);
		steps(3, 0, 6);
		snap(0);
		rdc(OFS_SCOUNT, 32'h0000_0005);
		rdc(OFS_SRAW, 32'h0000_0005);
		wr(OFS_CTRL, 32'h0000_0008);
		snap(0);
		rdc(OFS_SCOUNT, 32'h0000_0000);
		rdc(OFS_SPOS, 32'h0000_0000);
		rdc(OFS_SRAW, 32'h0000_0005);
		wr(OFS_CTRL, 32'h0000_0000);
		steps(5, 1, 6);
	endtask
	task automatic t_round();
		wr(OFS_CPR, 32'h0000_0004);
		chk_resp(RESP_OKAY);
		wr(OFS_SCALE, 32'h0000_0002);
		wr(OFS_CTRL, 32'h0000_0012);
		index[0] <= 1;
		repeat (8) @(posedge i_clock);
		index[0] <= 0;
		repeat (8) @(posedge i_clock);
		snap(0);
		rdc(OFS_SCOUNT, 32'h0000_0004);
		rdc(OFS_SRAW, 32'h0000_000a);
		rdc(OFS_SPOS, 32'h0002_0000);
		rdc(OFS_CTRL, 32'h0000_0002);
		chk_resp(RESP_OKAY);
	endtask
	task automatic t_fall();
		wr(OFS_CTRL, 32'h0000_0014);
		index[0] <= 1;
		repeat (8) @(posedge i_clock);
		snap(0);
		rdc(OFS_SCOUNT, 32'h0000_0004);
		rdc(OFS_CTRL, 32'h0000_0014);
		index[0] <= 0;
		repeat (8) @(posedge i_clock);
		snap(0);
		rdc(OFS_SCOUNT, 32'h0000_0000);
		rdc(OFS_CTRL, 32'h0000_0004);
	endtask
	task automatic t_vel();
		steps(3, 1, 20);
		snap(0);
		rdc(OFS_SVEL, 32'h0000_0014);
		repeat (300) @(posedge i_clock);
		snap(0);
		rdc(OFS_SVEL, 32'h0000_0000);
	endtask
	task automatic t_stepdir();
		wr(8'h10, 32'h0000_0001);
		mask <= 6'h02;
		axis <= 3'h1;
		steps(4, 1, 6);
		snap(1);
		rdc(OFS_SCOUNT, 32'h0000_0002);
	endtask
	// Main sequence after a 16-cycle reset.
	initial begin
		repeat (16) @(posedge i_clock);
		rst_n <= 1;
		repeat (2) @(posedge i_clock);
		t_reset();
		t_quad_clear();
		t_round();
		t_fall();
		t_vel();
		t_stepdir();
		test_done();
	end
endmodule
`default_nettype wire
